// ---- link_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// =====
// far side: link requests and non-posted completions
module link_partner (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  // request delivery
  input  wire logic       send_i,
  input  wire logic [1:0] link_i,
  output logic            req_arrive_o,
  output logic [1:0]      req_link_o,
  // completions
  input  wire logic       cpl_go_i,
  input  wire logic       np_issue_i,
  input  wire logic       np_stall_i,
  output logic            np_done_o
);
  logic [3:0] outst_reg;
  logic [1:0] last_reg;
  logic       take;
  logic       give;
  // refused issues owe no completion, so the model never frees a slot early
  assign take = np_issue_i && !np_stall_i;
  assign give = cpl_go_i && (outst_reg != 4'h0);
  // idle link lines show the inverse of the last id, never a stale copy
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      outst_reg    <= 4'h0;
      last_reg     <= 2'h0;
      req_arrive_o <= 1'b0;
      req_link_o   <= 2'h3;
      np_done_o    <= 1'b0;
    end else begin
      outst_reg    <= outst_reg + 4'(take) - 4'(give);
      last_reg     <= send_i ? link_i : last_reg;
      req_arrive_o <= send_i;
      req_link_o   <= send_i ? link_i : ~last_reg;
      np_done_o    <= give;
    end
  end
endmodule
`default_nettype wire

// ---- node_link_defs.svh ----
`ifndef NODE_LINK_DEFS_SVH
`define NODE_LINK_DEFS_SVH
// ==========================================================
// register offsets
`define XCTL_OFF        8'h60
`define LINIT_OFF       8'h6C
// ==========================================================
// transaction control upper fields
`define XCTL_RST        32'h0F00_0000
`define XCTL_WMASK      32'hFFFF_8000
`define B_CFG_LIMIT     15
`define B_LINT_EN       16
`define B_WIDE_BCAST    17
`define B_WIDE_ID       18
`define B_WIDE_SPUR     19
`define B_SRC_TAG       20
`define F_NP_LIMIT      22:21
`define B_INST_SHARED   23
`define F_MED_PASS_MAX  25:24
`define F_HI_PASS_MAX   27:26
`define B_CPURD_HI      28
`define B_WR_LO_DIS     29
`define B_ISOC_HI_DIS   30
`define B_ISOC_MED_DIS  31
// ==========================================================
// link init control fields
`define B_RT_BYPASS     0
`define B_REQ_BLOCK     1
`define F_LAST_LINK     3:2
`define B_COLD_SCR      4
`define B_FW_SCR0       5
`define B_INIT_SCR      6
`define F_FW_SCR21      10:9
// ==========================================================
// values
`define LINK_LOCAL_CPU  2'h3
`define BCAST_NARROW    8'h0F
`define BCAST_WIDE      8'hFF
`define SPUR_FIXED_LOW  4'hF
`define NP_LIM_01       4'h1
`define NP_LIM_10       4'h4
`define NP_LIM_11       4'h8
`endif

// ---- node_link_init_and_priority_ctrl.sv ----
// Overview of operation
// (RULE_01) limit bit redirects absent-node config accesses
// (RULE_02) firmware sets limit after fabric init
// (RULE_03) broadcast ExtInt/NMI become local interrupt lines
// (RULE_04) broadcast destination 0Fh or FFh
// (RULE_05) APIC identifier width four or eight
// (RULE_06) spurious vector low nibble fixed ones
// (RULE_07) tagging puts source node into SeqID
// (RULE_08) throttle outstanding downstream non-posted requests
// (RULE_09) fill install state shared or probe-based
// (RULE_10) medium passes counted, demote at maximum
// (RULE_11) high passes counted, demote at maximum
// (RULE_12) CPU reads medium, optionally high
// (RULE_13) plain writes low, optionally medium
// (RULE_14) isochronous writes high, medium or low
// (RULE_15) routing bypass resets one, default link
// (RULE_16) request block resets one except bootstrap
// (RULE_17) firmware clears blocks after table init
// (RULE_18) arrival link captured on each request; a CPU read in the same cycle wins and that arrival link is not captured
// (RULE_19) responses use captured link; local read 11b
// (RULE_20) cold scratch cleared only by cold reset
// (RULE_21) firmware scratch cleared only by cold reset
// (RULE_22) init scratch cleared by warm or cold
`timescale 1ns/1ps
`default_nettype none
`include "node_link_defs.svh"
module node_link_init_and_priority_ctrl (
  // clock and resets
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic       warm_reset_i,
  input  wire logic       init_event_i,
  input  wire logic       bootstrap_processor_i,
  // configuration register port
  input  wire logic       cfg_wr_i,
  input  wire logic       cfg_rd_i,
  input  wire logic [7:0] cfg_addr_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic [31:0]     cfg_rdata_o,
  output logic            cfg_rvalid_o,
  // config access routing
  input  wire logic       cfg_valid_i,
  input  wire logic [2:0] cfg_target_node_i,
  input  wire logic [2:0] node_count_i,
  output logic            cfg_to_noncoherent_o,
  // interrupts
  input  wire logic       extint_bcast_i,
  input  wire logic       nmi_bcast_i,
  input  wire logic       apic_hw_en_i,
  output logic [1:0]      local_interrupt_lines_o,
  output logic            extint_o,
  output logic            nmi_o,
  // APIC modes
  output logic [7:0]      apic_broadcast_id_o,
  output logic [7:0]      apic_id_mask_o,
  input  wire logic       spur_wr_i,
  input  wire logic [7:0] spur_wdata_i,
  output logic [7:0]      spur_vector_o,
  // downstream requests
  input  wire logic [3:0] seq_id_i,
  input  wire logic [3:0] src_node_i,
  output logic [3:0]      seq_id_o,
  input  wire logic       np_issue_i,
  input  wire logic       np_done_i,
  output logic            np_stall_o,
  // cache fill
  input  wire logic       probe_shared_i,
  output logic            install_shared_o,
  // priority arbitration
  input  wire logic [1:0] access_kind_i,
  output logic [1:0]      access_prio_o,
  input  wire logic       med_pass_i,
  input  wire logic       hi_pass_i,
  input  wire logic       arb_grant_i,
  output logic            med_demote_o,
  output logic            hi_demote_o,
  // link routing
  input  wire logic       req_arrive_i,
  input  wire logic [1:0] req_link_i,
  input  wire logic       cpu_read_i,
  output logic            routing_table_bypass_o,
  output logic            request_issue_block_o,
  output logic [1:0]      resp_link_o
);

  // ==========================================================
  // state
  logic        rt_bypass_reg, req_block_reg, cold_scr_reg, init_scr_reg;
  logic        rvalid_reg, redirect_reg, extint_reg, nmi_reg;
  logic [1:0]  last_link_reg, med_cnt_reg, hi_cnt_reg, lint_reg;
  logic [2:0]  fw_scr_reg;
  logic [3:0]  spur_hi_reg, spur_lo_reg, np_cnt_reg, seq_reg;
  logic [31:0] xctl_reg, rdata_reg;

  // ==========================================================
  // decode
  wire        wr_xctl   = cfg_wr_i && (cfg_addr_i == `XCTL_OFF);
  wire        wr_linit  = cfg_wr_i && (cfg_addr_i == `LINIT_OFF);
  wire        convert   = xctl_reg[`B_LINT_EN] && apic_hw_en_i;
  wire [1:0]  np_sel    = xctl_reg[`F_NP_LIMIT];
  wire [3:0]  np_limit  = (np_sel == 2'h1) ? `NP_LIM_01 :
                          (np_sel == 2'h2) ? `NP_LIM_10 : `NP_LIM_11;
  wire        np_full   = (np_sel != 2'h0) && (np_cnt_reg >= np_limit);
  wire        np_inc    = np_issue_i && !np_full;
  wire [31:0] linit_val = {21'h0, fw_scr_reg[2:1], 2'h0, init_scr_reg,
                           fw_scr_reg[0], cold_scr_reg, last_link_reg,
                           req_block_reg, rt_bypass_reg};
  wire [31:0] rd_mux    = (cfg_addr_i == `XCTL_OFF)  ? xctl_reg :
                          (cfg_addr_i == `LINIT_OFF) ? linit_val : 32'h0;

  // ==========================================================
  // transaction control: loaded with XCTL_RST by cold and warm reset
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || warm_reset_i) begin
      xctl_reg <= `XCTL_RST;
    end else if (wr_xctl) begin
      xctl_reg <= cfg_wdata_i & `XCTL_WMASK;
    end
  end

  // routing bypass and request block restart on cold or warm reset
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || warm_reset_i) begin
      rt_bypass_reg <= 1'b1;                                   // RULE_15
      req_block_reg <= !bootstrap_processor_i;                 // RULE_16
    end else if (wr_linit) begin
      rt_bypass_reg <= cfg_wdata_i[`B_RT_BYPASS];
      // hardware only sets, so software may only clear
      req_block_reg <= req_block_reg & cfg_wdata_i[`B_REQ_BLOCK]; // RULE_16
    end
  end

  // scratch bits survive what they are meant to detect
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cold_scr_reg <= 1'b0;                                    // RULE_20
      fw_scr_reg   <= 3'h0;                                    // RULE_21
    end else if (wr_linit) begin
      cold_scr_reg <= cfg_wdata_i[`B_COLD_SCR];
      fw_scr_reg   <= {cfg_wdata_i[`F_FW_SCR21], cfg_wdata_i[`B_FW_SCR0]};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i || warm_reset_i) begin
      init_scr_reg <= 1'b0;                                    // RULE_22
    end else if (wr_linit) begin
      init_scr_reg <= cfg_wdata_i[`B_INIT_SCR];
    end
  end

  // arrival link captured before the request is serviced
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || warm_reset_i) begin
      last_link_reg <= 2'h0;
    end else if (cpu_read_i) begin
      last_link_reg <= `LINK_LOCAL_CPU;                        // RULE_19
    end else if (req_arrive_i) begin
      last_link_reg <= req_link_i;                             // RULE_18
    end
  end

  // ==========================================================
  // register read port, one cycle latency
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_reg  <= 32'h0;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= cfg_rd_i ? rd_mux : rdata_reg;
      rvalid_reg <= cfg_rd_i;
    end
  end

  // ==========================================================
  // spurious vector, low nibble only stored when wide mode is on
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || warm_reset_i) begin
      spur_hi_reg <= 4'h0;
      spur_lo_reg <= `SPUR_FIXED_LOW;
    end else if (spur_wr_i) begin
      spur_hi_reg <= spur_wdata_i[7:4];
      if (xctl_reg[`B_WIDE_SPUR]) begin
        spur_lo_reg <= spur_wdata_i[3:0];                      // RULE_06
      end
    end
  end

  // ==========================================================
  // request-path outputs, registered
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      redirect_reg <= 1'b0;
      lint_reg     <= 2'h0;
      extint_reg   <= 1'b0;
      nmi_reg      <= 1'b0;
      seq_reg      <= 4'h0;
    end else begin
      redirect_reg <= cfg_valid_i && xctl_reg[`B_CFG_LIMIT]
                      && (cfg_target_node_i > node_count_i);   // RULE_01
      lint_reg     <= {nmi_bcast_i && convert, extint_bcast_i && convert}; // RULE_03
      extint_reg   <= extint_bcast_i && !convert;
      nmi_reg      <= nmi_bcast_i && !convert;
      seq_reg      <= xctl_reg[`B_SRC_TAG] ? src_node_i : seq_id_i; // RULE_07
    end
  end

  // ==========================================================
  // outstanding non-posted counter; issue is refused while full
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || warm_reset_i) begin
      np_cnt_reg <= 4'h0;
    end else if (np_inc && !(np_done_i && np_cnt_reg != 4'h0)) begin
      np_cnt_reg <= np_cnt_reg + 4'h1;                         // RULE_08
    end else if (!np_inc && np_done_i && np_cnt_reg != 4'h0) begin
      np_cnt_reg <= np_cnt_reg - 4'h1;
    end
  end

  // ==========================================================
  // bypass counters: a grant while demoted restarts the count
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || warm_reset_i) begin
      med_cnt_reg <= 2'h0;
      hi_cnt_reg  <= 2'h0;
    end else begin
      if (med_demote_o && arb_grant_i) begin
        med_cnt_reg <= 2'h0;                                   // RULE_10
      end else if (med_pass_i && !med_demote_o) begin
        med_cnt_reg <= med_cnt_reg + 2'h1;
      end
      if (hi_demote_o && arb_grant_i) begin
        hi_cnt_reg <= 2'h0;                                    // RULE_11
      end else if (hi_pass_i && !hi_demote_o) begin
        hi_cnt_reg <= hi_cnt_reg + 2'h1;
      end
    end
  end

  // ==========================================================
  // priority classification
  wire       isoc_hi_dis  = xctl_reg[`B_ISOC_HI_DIS];
  wire       isoc_med_dis = xctl_reg[`B_ISOC_MED_DIS];
  wire [1:0] isoc_prio    = !isoc_hi_dis  ? node_link_pkg::PRIO_HIGH :
                            !isoc_med_dis ? node_link_pkg::PRIO_MED :
                                            node_link_pkg::PRIO_LOW;  // RULE_14
  wire [1:0] rd_prio      = xctl_reg[`B_CPURD_HI] ? node_link_pkg::PRIO_HIGH
                                                  : node_link_pkg::PRIO_MED; // RULE_12
  wire [1:0] wr_prio      = xctl_reg[`B_WR_LO_DIS] ? node_link_pkg::PRIO_MED
                                                   : node_link_pkg::PRIO_LOW; // RULE_13

  assign access_prio_o =
    (access_kind_i == node_link_pkg::KIND_CPU_READ) ? rd_prio :
    (access_kind_i == node_link_pkg::KIND_WRITE)    ? wr_prio :
    (access_kind_i == node_link_pkg::KIND_ISOC_WR)  ? isoc_prio :
                                                      node_link_pkg::PRIO_MED;

  // ==========================================================
  // outputs
  assign med_demote_o         = (med_cnt_reg >= xctl_reg[`F_MED_PASS_MAX]); // RULE_10
  assign hi_demote_o          = (hi_cnt_reg >= xctl_reg[`F_HI_PASS_MAX]);   // RULE_11
  assign np_stall_o           = np_full;                                   // RULE_08
  assign install_shared_o     = xctl_reg[`B_INST_SHARED] || probe_shared_i; // RULE_09
  assign apic_broadcast_id_o  = xctl_reg[`B_WIDE_BCAST] ? `BCAST_WIDE
                                                        : `BCAST_NARROW;   // RULE_04
  assign apic_id_mask_o       = xctl_reg[`B_WIDE_ID] ? `BCAST_WIDE
                                                     : `BCAST_NARROW;      // RULE_05
  assign spur_vector_o        = {spur_hi_reg, xctl_reg[`B_WIDE_SPUR] ? spur_lo_reg
                                                     : `SPUR_FIXED_LOW};   // RULE_06
  assign cfg_rdata_o          = rdata_reg;
  assign cfg_rvalid_o         = rvalid_reg;
  assign cfg_to_noncoherent_o = redirect_reg;
  assign local_interrupt_lines_o = lint_reg;
  assign extint_o             = extint_reg;
  assign nmi_o                = nmi_reg;
  assign seq_id_o             = seq_reg;
  assign routing_table_bypass_o = rt_bypass_reg;                           // RULE_15
  assign request_issue_block_o  = req_block_reg;                           // RULE_16
  assign resp_link_o          = last_link_reg;                             // RULE_19

  // ==========================================================
  // checks
  property p_redirect;
    @(posedge mclk_i) disable iff (!rstn_i)
    cfg_valid_i && xctl_reg[`B_CFG_LIMIT] && (cfg_target_node_i > node_count_i)
      |=> cfg_to_noncoherent_o;
  endproperty
  a_redirect: assert property (p_redirect) else $error("config not redirected"); // RULE_01
  property p_lint;
    @(posedge mclk_i) disable iff (!rstn_i)
    extint_bcast_i && xctl_reg[`B_LINT_EN] && apic_hw_en_i
      |=> local_interrupt_lines_o[0] && !extint_o;
  endproperty
  a_lint: assert property (p_lint) else $error("extint not converted"); // RULE_03
  property p_bcast;
    @(posedge mclk_i) disable iff (!rstn_i)
    apic_broadcast_id_o == (xctl_reg[`B_WIDE_BCAST] ? 8'hFF : 8'h0F);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast id wrong"); // RULE_04
  property p_spur;
    @(posedge mclk_i) disable iff (!rstn_i)
    !xctl_reg[`B_WIDE_SPUR] |-> spur_vector_o[3:0] == 4'hF;
  endproperty
  a_spur: assert property (p_spur) else $error("spurious nibble not fixed"); // RULE_06
  property p_np_one;
    @(posedge mclk_i) disable iff (!rstn_i)
    (xctl_reg[`F_NP_LIMIT] == 2'h1) && (np_cnt_reg != 4'h0) |-> np_stall_o;
  endproperty
  a_np_one: assert property (p_np_one) else $error("limit of one exceeded"); // RULE_08
  property p_med;
    @(posedge mclk_i) disable iff (!rstn_i || warm_reset_i)
    med_pass_i && !med_demote_o && !arb_grant_i && !wr_xctl
      && (med_cnt_reg + 2'h1 == xctl_reg[`F_MED_PASS_MAX]) |=> med_demote_o;
  endproperty
  a_med: assert property (p_med) else $error("medium demote missed"); // RULE_10
  property p_rd_prio;
    @(posedge mclk_i) disable iff (!rstn_i)
    access_kind_i == node_link_pkg::KIND_CPU_READ && !xctl_reg[`B_CPURD_HI]
      |-> access_prio_o == node_link_pkg::PRIO_MED;
  endproperty
  a_rd_prio: assert property (p_rd_prio) else $error("cpu read priority"); // RULE_12
  property p_rt_reset;
    @(posedge mclk_i)
    !rstn_i |=> routing_table_bypass_o;
  endproperty
  a_rt_reset: assert property (p_rt_reset) else $error("bypass not set"); // RULE_15
  property p_link;
    @(posedge mclk_i) disable iff (!rstn_i || warm_reset_i)
    req_arrive_i && !cpu_read_i |=> resp_link_o == $past(req_link_i);
  endproperty
  a_link: assert property (p_link) else $error("link not captured"); // RULE_18
  property p_cold_keep;
    @(posedge mclk_i) disable iff (!rstn_i)
    warm_reset_i && !wr_linit |=> $stable(cold_scr_reg) && $stable(fw_scr_reg);
  endproperty
  a_cold_keep: assert property (p_cold_keep) else $error("scratch lost"); // RULE_20
  c_stall: cover property (@(posedge mclk_i) disable iff (!rstn_i) np_stall_o);
  c_hidem: cover property (@(posedge mclk_i) disable iff (!rstn_i)
                           hi_demote_o && arb_grant_i);
  c_local: cover property (@(posedge mclk_i) disable iff (!rstn_i)
                           resp_link_o == 2'h3);
  c_init: cover property (@(posedge mclk_i) disable iff (!rstn_i) init_event_i && init_scr_reg);
endmodule
`default_nettype wire

// ---- node_link_pkg.sv ----
`default_nettype none
package node_link_pkg;
  // access priority classes
  typedef enum logic [1:0] {
    PRIO_LOW  = 2'h0,
    PRIO_MED  = 2'h1,
    PRIO_HIGH = 2'h2
  } prio_t;
  // kinds of access seen by the arbiter
  typedef enum logic [1:0] {
    KIND_CPU_READ  = 2'h0,
    KIND_WRITE     = 2'h1,
    KIND_ISOC_WR   = 2'h2,
    KIND_OTHER     = 2'h3
  } kind_t;
endpackage
`default_nettype wire

// ---- tb_node_link_init_and_priority_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "node_link_defs.svh"
module tb_node_link_init_and_priority_ctrl;
  // =====
  // stimulus and observed signals
  logic mclk_i = 1'b0;
  logic rstn_i, warm_reset_i, init_event_i, bootstrap_processor_i, cfg_wr_i, cfg_rd_i;
  logic cfg_valid_i, extint_bcast_i, nmi_bcast_i, apic_hw_en_i, spur_wr_i, np_issue_i;
  logic probe_shared_i, med_pass_i, hi_pass_i, arb_grant_i, cpu_read_i, send, cpl_go;
  logic np_done_i, req_arrive_i, cfg_rvalid_o, cfg_to_noncoherent_o, extint_o, nmi_o;
  logic np_stall_o, install_shared_o, med_demote_o, hi_demote_o;
  logic routing_table_bypass_o, request_issue_block_o;
  logic [1:0]  link, req_link_i, access_kind_i, local_interrupt_lines_o, access_prio_o;
  logic [1:0]  resp_link_o;
  logic [2:0]  cfg_target_node_i, node_count_i;
  logic [3:0]  seq_id_i, src_node_i, seq_id_o;
  logic [7:0]  cfg_addr_i, spur_wdata_i, apic_broadcast_id_o, apic_id_mask_o, spur_vector_o;
  logic [31:0] cfg_wdata_i, cfg_rdata_o, r;
  logic [31:0] exp_q[$];
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          lims[4] = '{9, 1, 4, 8};

  node_link_init_and_priority_ctrl dut (.mclk_i, .rstn_i, .warm_reset_i, .init_event_i,
    .bootstrap_processor_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o,
    .cfg_rvalid_o, .cfg_valid_i, .cfg_target_node_i, .node_count_i, .cfg_to_noncoherent_o,
    .extint_bcast_i, .nmi_bcast_i, .apic_hw_en_i, .local_interrupt_lines_o, .extint_o, .nmi_o,
    .apic_broadcast_id_o, .apic_id_mask_o, .spur_wr_i, .spur_wdata_i, .spur_vector_o,
    .seq_id_i, .src_node_i, .seq_id_o, .np_issue_i, .np_done_i, .np_stall_o, .probe_shared_i,
    .install_shared_o, .access_kind_i, .access_prio_o, .med_pass_i, .hi_pass_i, .arb_grant_i,
    .med_demote_o, .hi_demote_o, .req_arrive_i, .req_link_i, .cpu_read_i,
    .routing_table_bypass_o, .request_issue_block_o, .resp_link_o);
  link_partner far (.mclk_i, .rstn_i, .send_i(send), .link_i(link),
    .req_arrive_o(req_arrive_i), .req_link_o(req_link_i), .cpl_go_i(cpl_go),
    .np_issue_i, .np_stall_i(np_stall_o), .np_done_o(np_done_i));

  // 25 MHz clock
  always #20 mclk_i = ~mclk_i;

  // =====
  // checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    cfg_wr_i    <= 1'b1;
    cfg_addr_i  <= a;
    cfg_wdata_i <= d;
    @(posedge mclk_i);
    cfg_wr_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge mclk_i);
    cfg_rd_i   <= 1'b1;
    cfg_addr_i <= a;
    @(posedge mclk_i);
    cfg_rd_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic rst(input logic warm, input int n);
    @(posedge mclk_i);
    if (warm) warm_reset_i <= 1'b1;
    else rstn_i <= 1'b0;
    repeat (n) @(posedge mclk_i);
    warm_reset_i <= 1'b0;
    rstn_i       <= 1'b1;
    @(negedge mclk_i);
  endtask
  function automatic logic [1:0] prio_of(input logic [3:0] c, input int k);
    if (k == 0) return c[0] ? 2'h2 : 2'h1;
    if (k == 1) return c[1] ? 2'h1 : 2'h0;
    if (k == 3) return 2'h1;
    return !c[2] ? 2'h2 : (c[3] ? 2'h0 : 2'h1);
  endfunction
  task automatic summarize();
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("BAD %0t reads left unanswered", $time);
    end
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // read data is matched against the oldest noted expectation
  always @(negedge mclk_i) begin
    if (cfg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) chk(cfg_rvalid_o, 1'b0);
      else chk(cfg_rdata_o, exp_q.pop_front());
    end
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end

  // =====
  // main sequence
  initial begin
    {rstn_i, warm_reset_i, init_event_i, bootstrap_processor_i, cfg_wr_i, cfg_rd_i} = '0;
    {cfg_valid_i, extint_bcast_i, nmi_bcast_i, apic_hw_en_i, spur_wr_i, np_issue_i} = '0;
    {probe_shared_i, med_pass_i, hi_pass_i, arb_grant_i, cpu_read_i, send, cpl_go} = '0;
    {link, access_kind_i, cfg_target_node_i, node_count_i, seq_id_i, src_node_i} = '0;
    {cfg_addr_i, spur_wdata_i, cfg_wdata_i} = '0;
    void'($urandom(32'h193610A0));
    rst(1'b0, 20);
    // reset values, unmapped place, masked write-back
    rd(8'h60, `XCTL_RST);
    rd(8'h6C, 32'h3);
    rd(8'h70, 32'h0);
    wr(8'h70, $urandom);
    r = $urandom;
    wr(8'h60, r);
    rd(8'h60, r & `XCTL_WMASK);
    // every priority control setting against every access kind
    for (int c = 0; c < 16; c++) begin
      wr(8'h60, 32'(c) << 28);
      for (int k = 0; k < 4; k++) begin
        @(posedge mclk_i);
        access_kind_i <= 2'(k);
        @(negedge mclk_i);
        chk(access_prio_o, prio_of(4'(c), k));
      end
    end
    // apic modes, tagging and install state
    for (int i = 0; i < 16; i++) begin
      wr(8'h60, (32'(i) << 17) | (32'(i[3]) << 23));
      r = $urandom;
      @(posedge mclk_i);
      spur_wr_i      <= 1'b1;
      spur_wdata_i   <= r[7:0];
      seq_id_i       <= r[11:8];
      src_node_i     <= r[15:12];
      probe_shared_i <= r[16];
      @(posedge mclk_i);
      spur_wr_i <= 1'b0;
      @(negedge mclk_i);
      chk(apic_broadcast_id_o, i[0] ? 8'hFF : 8'h0F);
      chk(apic_id_mask_o, i[1] ? 8'hFF : 8'h0F);
      chk(spur_vector_o, i[2] ? r[7:0] : {r[7:4], 4'hF});
      chk(seq_id_o, i[3] ? r[15:12] : r[11:8]);
      chk(install_shared_o, i[3] | r[16]);
    end
    // throttle: one short of the limit, then one refused issue past it
    for (int e = 0; e < 4; e++) begin
      wr(8'h60, 32'(e) << 21);
      if (lims[e] > 1) begin
        @(posedge mclk_i);
        np_issue_i <= 1'b1;
        repeat (lims[e] - 1) @(posedge mclk_i);
        np_issue_i <= 1'b0;
      end
      @(negedge mclk_i);
      chk(np_stall_o, 1'b0);
      @(posedge mclk_i);
      np_issue_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      np_issue_i <= 1'b0;
      @(negedge mclk_i);
      chk(np_stall_o, e != 0);
      @(posedge mclk_i);
      cpl_go <= 1'b1;
      repeat (12) @(posedge mclk_i);
      cpl_go <= 1'b0;
      @(negedge mclk_i);
      chk(np_stall_o, 1'b0);
    end
    // pass counters reach their maximum exactly, grant clears
    for (int m = 0; m < 4; m++) begin
      wr(8'h60, (32'(m) << 24) | (32'(m) << 26));
      chk({med_demote_o, hi_demote_o}, (m == 0) ? 2'h3 : 2'h0);
      for (int p = 0; p < m; p++) begin
        @(posedge mclk_i);
        {med_pass_i, hi_pass_i} <= 2'h3;
        @(posedge mclk_i);
        {med_pass_i, hi_pass_i} <= 2'h0;
        @(negedge mclk_i);
        chk({med_demote_o, hi_demote_o}, (p == m - 1) ? 2'h3 : 2'h0);
      end
      @(posedge mclk_i);
      arb_grant_i <= 1'b1;
      @(posedge mclk_i);
      arb_grant_i <= 1'b0;
      @(negedge mclk_i);
      chk({med_demote_o, hi_demote_o}, (m == 0) ? 2'h3 : 2'h0);
    end
    // config redirect, limit set once the fabric is up
    for (int i = 0; i < 16; i++) begin
      if (i == 8) wr(8'h60, 32'h0000_8000);
      r = $urandom;
      @(posedge mclk_i);
      cfg_valid_i       <= 1'b1;
      cfg_target_node_i <= r[2:0];
      node_count_i      <= r[5:3];
      @(posedge mclk_i);
      cfg_valid_i <= 1'b0;
      @(negedge mclk_i);
      chk(cfg_to_noncoherent_o, i >= 8 && r[2:0] > r[5:3]);
    end
    // interrupt conversion with and without apic enable
    for (int i = 0; i < 8; i++) begin
      wr(8'h60, 32'(i[2]) << 16);
      @(posedge mclk_i);
      apic_hw_en_i   <= i[1];
      extint_bcast_i <= !i[0];
      nmi_bcast_i    <= i[0];
      @(posedge mclk_i);
      {extint_bcast_i, nmi_bcast_i} <= 2'h0;
      @(negedge mclk_i);
      chk({local_interrupt_lines_o, extint_o, nmi_o}, (i[2] & i[1]) ?
        {i[0], !i[0], 2'b00} : {2'b00, !i[0], i[0]});
    end
    // arrival link capture, local cpu read last
    for (int l = 0; l < 4; l++) begin
      @(posedge mclk_i);
      send       <= (l < 3);
      link       <= 2'(l);
      cpu_read_i <= (l == 3);
      @(posedge mclk_i);
      {send, cpu_read_i} <= 2'h0;
      repeat (2) @(negedge mclk_i);
      chk(resp_link_o, l);
      rd(8'h6C, 32'h3 | (32'(l) << 2));
    end
    // firmware clears the blocks after table set-up; writing one cannot set
    wr(8'h6C, 32'h2);
    rd(8'h6C, 32'hE);
    chk({routing_table_bypass_o, request_issue_block_o}, 2'h1);
    wr(8'h6C, 32'h0);
    wr(8'h6C, 32'hFFFF_FFFE);
    rd(8'h6C, 32'h67C);
    chk({routing_table_bypass_o, request_issue_block_o}, 2'h0);
    // init event keeps scratch; warm keeps cold and firmware scratch, clears init scratch
    @(posedge mclk_i);
    {init_event_i, send} <= 2'h3;
    link <= 2'h0;
    @(posedge mclk_i);
    {init_event_i, send} <= 2'h0;
    rd(8'h6C, 32'h670);
    rst(1'b1, 1);
    rd(8'h6C, 32'h633);
    rd(8'h60, `XCTL_RST);
    chk(spur_vector_o, 8'h0F);
    // cold reset on the bootstrap node clears every scratch bit
    @(posedge mclk_i);
    bootstrap_processor_i <= 1'b1;
    rst(1'b0, 2);
    rd(8'h6C, 32'h1);
    repeat (4) @(posedge mclk_i);
    summarize();
  end
endmodule
`default_nettype wire
